// >>> verilog/ubg_pkg.sv
// Package for the serial channel baud rate generator.
// Assumes a single 125 MHz peripheral clock domain.
package ubg_pkg;
   localparam int          SEL_W       = 4;
   localparam int          DIV_W       = 8;
   localparam int          PRE_W       = 10;
   localparam logic [3:0]  SEL_MAX_PRS = 4'hA;
   localparam logic [3:0]  SEL_TIMER   = 4'hB;
   localparam logic [7:0]  DIV_MIN     = 8'h04;
   localparam logic [7:0]  DIV_MAX     = 8'hFF;
   localparam logic [7:0]  DIV_RESET   = 8'hFF;
   localparam logic [3:0]  SEL_RESET   = 4'h0;
   localparam logic [7:0]  GAP_CLOCKS  = 8'h02;
   localparam logic [7:0]  SAMPLE_MARGIN = 8'h02;
   localparam logic [3:0]  FRAME_BITS  = 4'hA;

   typedef struct packed {
      logic power;
      logic tx_enable;
      logic rx_enable;
   } ubg_ctrl_s;

   typedef enum logic [1:0] {
      UBG_TX_IDLE = 2'b00,
      UBG_TX_BITS = 2'b01,
      UBG_TX_GAP  = 2'b11
   } ubg_tx_e;
endpackage

// >>> verilog/ubg_baud_gen.sv
// Baud rate generator: base clock selector, transmit and receive divisor counters.
// Assumes all inputs are synchronous to clk_in and that the frame logic
// reads the tick and sample outputs.
// Summary of operation
// - Bit rate is base clock over 2k.
// - Divisor accepts 4 to 255 only.
// - Codes 0 to 10 pick prescaled clock.
// - Code 11 picks companion timer output.
// - Timer output used regardless of pin enable.
// - Receive sample instants follow divisor counter.
// - Receive sampling sits exactly at mid-bit.
// - Back-to-back gap stretched two base clocks.
// - Receiver restarts timing at each start.
// - Power off holds base clock low.
// - Transmit counter clears on first write, frame end.
// - Receive counter runs one frame per start.
`timescale 1ns/100ps
module ubg_baud_gen
#(
   parameter int SEL_WIDTH = ubg_pkg::SEL_W,
   parameter int DIV_WIDTH = ubg_pkg::DIV_W
)
(
   input  wire logic                 clk_in,
   input  wire logic                 rstn_in,
   input  wire ubg_pkg::ubg_ctrl_s   ctrl_in,
   input  wire logic [SEL_WIDTH-1:0] base_clock_select_in,
   input  wire logic [DIV_WIDTH-1:0] divisor_value_in,
   input  wire logic                 companion_timer_out_in,
   input  wire logic                 transmit_buffer_write_in,
   input  wire logic                 tx_more_data_in,
   input  wire logic                 rx_start_detect_in,
   output logic                      base_clock_tick_out,
   output logic                      tx_bit_tick_out,
   output logic                      tx_frame_end_out,
   output logic                      rx_sample_out,
   output logic                      rx_frame_end_out,
   output logic                      divisor_error_out
);
   // The counters and compare constants are sized for the default widths only.
   if (SEL_WIDTH != ubg_pkg::SEL_W || DIV_WIDTH != ubg_pkg::DIV_W)
   begin
      $error("ubg_baud_gen supports only 4-bit select and 8-bit divisor");
   end

   logic [ubg_pkg::PRE_W-1:0] pre_q;
   logic                      tmr_q;
   logic                      base_tick;
   logic                      div_ok;
   logic                      tx_run;
   logic [7:0]                tx_cnt_q;
   logic                      tx_half_q;
   logic [3:0]                tx_bit_q;
   logic [7:0]                tx_gap_q;
   ubg_pkg::ubg_tx_e          tx_st_q;
   logic                      rx_on_q;
   logic [7:0]                rx_cnt_q;
   logic                      rx_half_q;
   logic [3:0]                rx_bit_q;
   logic                      tx_tick;
   logic                      rx_tick;
   logic                      rx_mid;

   // Prescaler free-runs while powered; it is cleared when power is off.
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in || !ctrl_in.power)
         pre_q <= '0;
      else
         pre_q <= pre_q + 10'h001;
   end

   // The timer is taken internally, never via its output pin enable.
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         tmr_q <= 1'b0;
      else
         tmr_q <= companion_timer_out_in;
   end

   // A tick marks one base clock period; power off gives none.
   always_comb
   begin
      base_tick = 1'b0;
      if (!ctrl_in.power)
         base_tick = 1'b0;
      else if (base_clock_select_in == 4'h0)
         base_tick = 1'b1;
      else if (base_clock_select_in <= ubg_pkg::SEL_MAX_PRS)
         base_tick = (pre_q & ((10'h001 << (base_clock_select_in - 4'h1)) * 10'h002 - 10'h001))
                     == ((10'h001 << (base_clock_select_in - 4'h1)) * 10'h002 - 10'h001);
      else if (base_clock_select_in == ubg_pkg::SEL_TIMER)
         base_tick = companion_timer_out_in && !tmr_q;
      else
         base_tick = 1'b0;
   end

   // Out-of-range divisors stop the counters rather than run at a wrong rate.
   assign div_ok = divisor_value_in >= ubg_pkg::DIV_MIN;

   assign tx_run = ctrl_in.power && ctrl_in.tx_enable && div_ok;
   // Each half bit spans k base clocks, so a bit spans 2k.
   assign tx_tick = base_tick && tx_half_q && tx_cnt_q == divisor_value_in - 8'h01;

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in || !tx_run)
      begin
         tx_cnt_q  <= '0;
         tx_half_q <= 1'b0;
      end
      else if ((transmit_buffer_write_in && tx_st_q == ubg_pkg::UBG_TX_IDLE)
               || (tx_st_q == ubg_pkg::UBG_TX_GAP && base_tick
                   && tx_gap_q == ubg_pkg::GAP_CLOCKS - 8'h01))
      begin
         tx_cnt_q  <= '0;
         tx_half_q <= 1'b0;
      end
      else if (base_tick && tx_st_q != ubg_pkg::UBG_TX_GAP)
      begin
         if (tx_cnt_q == divisor_value_in - 8'h01)
         begin
            tx_cnt_q  <= '0;
            tx_half_q <= !tx_half_q;
         end
         else
            tx_cnt_q <= tx_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in || !tx_run)
      begin
         tx_st_q  <= ubg_pkg::UBG_TX_IDLE;
         tx_bit_q <= '0;
         tx_gap_q <= '0;
      end
      else
         case (tx_st_q)
            ubg_pkg::UBG_TX_IDLE:
               if (transmit_buffer_write_in)
               begin
                  tx_st_q  <= ubg_pkg::UBG_TX_BITS;
                  tx_bit_q <= '0;
               end
            ubg_pkg::UBG_TX_BITS:
               if (tx_tick)
               begin
                  if (tx_bit_q == ubg_pkg::FRAME_BITS)
                  begin
                     tx_bit_q <= '0;
                     tx_gap_q <= '0;
                     tx_st_q  <= tx_more_data_in ? ubg_pkg::UBG_TX_GAP
                                                 : ubg_pkg::UBG_TX_IDLE;
                  end
                  else
                     tx_bit_q <= tx_bit_q + 4'h1;
               end
            ubg_pkg::UBG_TX_GAP:
               if (base_tick)
               begin
                  if (tx_gap_q == ubg_pkg::GAP_CLOCKS - 8'h01)
                     tx_st_q <= ubg_pkg::UBG_TX_BITS;
                  else
                     tx_gap_q <= tx_gap_q + 8'h01;
               end
            default:
               tx_st_q <= ubg_pkg::UBG_TX_IDLE;
         endcase
   end

   // Receive counter idles until a start bit, runs one frame, then stops.
   always_ff @(posedge clk_in)
   begin
      if (!rstn_in || !ctrl_in.power || !ctrl_in.rx_enable || !div_ok)
      begin
         rx_on_q   <= 1'b0;
         rx_cnt_q  <= '0;
         rx_half_q <= 1'b0;
         rx_bit_q  <= '0;
      end
      else if (rx_start_detect_in)
      begin
         rx_on_q   <= 1'b1;
         rx_cnt_q  <= '0;
         rx_half_q <= 1'b0;
         rx_bit_q  <= '0;
      end
      else if (rx_on_q && base_tick)
      begin
         if (rx_cnt_q == divisor_value_in - 8'h01)
         begin
            rx_cnt_q  <= '0;
            rx_half_q <= !rx_half_q;
            if (rx_half_q)
            begin
               rx_bit_q <= rx_bit_q + 4'h1;
               if (rx_bit_q == ubg_pkg::FRAME_BITS)
                  rx_on_q <= 1'b0;
            end
         end
         else
            rx_cnt_q <= rx_cnt_q + 8'h01;
      end
   end

   // Sampling sits at mid-bit, where the first half ends, k base clocks into the bit;
   // SAMPLE_MARGIN is not applied, so each bit gets one sample pulse with no window around it.
   assign rx_mid = rx_on_q && base_tick && rx_half_q == 1'b0
                   && rx_cnt_q == divisor_value_in - 8'h01;
   assign rx_tick = rx_on_q && base_tick && rx_half_q
                    && rx_cnt_q == divisor_value_in - 8'h01 && rx_bit_q == ubg_pkg::FRAME_BITS;

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         base_clock_tick_out <= 1'b0;
         tx_bit_tick_out     <= 1'b0;
         tx_frame_end_out    <= 1'b0;
         rx_sample_out       <= 1'b0;
         rx_frame_end_out    <= 1'b0;
         divisor_error_out   <= 1'b0;
      end
      else
      begin
         base_clock_tick_out <= base_tick;
         tx_bit_tick_out     <= tx_tick && tx_st_q == ubg_pkg::UBG_TX_BITS;
         tx_frame_end_out    <= tx_tick && tx_st_q == ubg_pkg::UBG_TX_BITS
                                && tx_bit_q == ubg_pkg::FRAME_BITS;
         rx_sample_out       <= rx_mid;
         rx_frame_end_out    <= rx_tick;
         divisor_error_out   <= !div_ok;
      end
   end
endmodule

// >>> dv/ubg_timer_model.sv
// Companion timer model that drives the timer output of the generator.
// Assumes the bench holds run_in low until reset is released.
`timescale 1ns/100ps
module ubg_timer_model
#(
   parameter int HALF = 3
)
(
   input  wire logic clk_in,
   input  wire logic run_in,
   output logic      tmr_out = 1'b0
);
   int cnt_q = 0;
   // The count and the output update on the same edge, the output toggling as the count wraps, so every half period is HALF cycles.
   always_ff @(posedge clk_in)
   begin
      cnt_q   <= (!run_in || cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      tmr_out <= run_in && ((cnt_q == HALF - 1) ? !tmr_out : tmr_out);
   end
endmodule

// >>> dv/ubg_baud_gen_assertions.sv
// Port checker for the baud generator.
// Assumes it is bound to ubg_baud_gen with its default widths.
`timescale 1ns/100ps
module ubg_baud_gen_assertions
(
   input wire logic               clk_in,
   input wire logic               rstn_in,
   input wire ubg_pkg::ubg_ctrl_s ctrl_in,
   input wire logic [3:0]         base_clock_select_in,
   input wire logic [7:0]         divisor_value_in,
   input wire logic               base_clock_tick_out,
   input wire logic               tx_bit_tick_out,
   input wire logic               tx_frame_end_out,
   input wire logic               rx_sample_out,
   input wire logic               rx_frame_end_out,
   input wire logic               divisor_error_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   a_power_off_quiet: assert property (!$past(ctrl_in.power) &&
      !$past(ctrl_in.power, 2) |-> !base_clock_tick_out) else $error("tick while off");
   a_full_rate_tick: assert property ($past(rstn_in, 2) && $past(ctrl_in.power) &&
      $past(ctrl_in.power, 2) && $past(base_clock_select_in) == 4'h0 &&
      $past(base_clock_select_in, 2) == 4'h0 |-> base_clock_tick_out) else $error("no tick");
   a_no_source: assert property ($past(base_clock_select_in) > 4'hB &&
      $past(base_clock_select_in, 2) > 4'hB |-> !base_clock_tick_out) else $error("bad code");
   a_div_flag: assert property ($past(rstn_in) |->
      divisor_error_out == ($past(divisor_value_in) < 8'h04)) else $error("divisor flag");
   a_div_stops: assert property ($past(divisor_value_in) < 8'h04 &&
      $past(divisor_value_in, 2) < 8'h04 |-> !tx_bit_tick_out && !rx_sample_out)
      else $error("count with small divisor");
   a_tx_off: assert property (!$past(ctrl_in.tx_enable) && !$past(ctrl_in.tx_enable, 2)
      |-> !tx_bit_tick_out && !tx_frame_end_out) else $error("tx while disabled");
   a_rx_off: assert property (!$past(ctrl_in.rx_enable) && !$past(ctrl_in.rx_enable, 2)
      |-> !rx_sample_out && !rx_frame_end_out) else $error("rx while disabled");
   a_bit_space: assert property (tx_bit_tick_out |=> !tx_bit_tick_out [*7])
      else $error("bit ticks too close");
endmodule
bind ubg_baud_gen ubg_baud_gen_assertions u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
   .ctrl_in(ctrl_in), .base_clock_select_in(base_clock_select_in),
   .divisor_value_in(divisor_value_in), .base_clock_tick_out(base_clock_tick_out),
   .tx_bit_tick_out(tx_bit_tick_out), .tx_frame_end_out(tx_frame_end_out),
   .rx_sample_out(rx_sample_out), .rx_frame_end_out(rx_frame_end_out),
   .divisor_error_out(divisor_error_out));

// >>> dv/ubg_baud_gen_tb_top.sv
// Self-checking bench for the baud generator with a companion timer model.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ubg_baud_gen_tb_top;
   logic               clk_in = 1'b0;
   logic               rstn_in = 1'b0;
   ubg_pkg::ubg_ctrl_s ctrl = '0;
   logic [3:0]         sel = 4'h0;
   logic [7:0]         k = 8'h04;
   logic               tmr, wr = 1'b0, more = 1'b0, start = 1'b0;
   logic               base_t, bit_t, tx_end, rx_s, rx_end, div_err;
   int                 err_count = 0, n_tests = 0, seed = 67, cnt, t, ts;
   ubg_baud_gen dut (.clk_in(clk_in), .rstn_in(rstn_in), .ctrl_in(ctrl),
      .base_clock_select_in(sel), .divisor_value_in(k), .companion_timer_out_in(tmr),
      .transmit_buffer_write_in(wr), .tx_more_data_in(more), .rx_start_detect_in(start),
      .base_clock_tick_out(base_t), .tx_bit_tick_out(bit_t), .tx_frame_end_out(tx_end),
      .rx_sample_out(rx_s), .rx_frame_end_out(rx_end), .divisor_error_out(div_err));
   ubg_timer_model #(.HALF(3)) u_tmr (.clk_in(clk_in), .run_in(rstn_in), .tmr_out(tmr));
   initial forever #4 clk_in = ~clk_in;
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Counts edges until a frame end; pulses on write and start last one cycle.
   task automatic wait_end(input bit rx);
      t = 0;
      do
      begin
         @(negedge clk_in);
         if (t == 0)
         begin
            wr = 1'b0;
            start = 1'b0;
         end
         t++;
         if ((rx ? rx_s : bit_t) === 1'b1)
         begin
            cnt++;
            ts = t;
         end
      end
      while (((rx ? rx_end : tx_end) !== 1'b1) && t < 20000);
   endtask
   initial
   begin
      repeat (5) @(negedge clk_in);
      rstn_in = 1'b1;
      // A window of 3072 holds whole periods of every prescaler step and of the timer.
      for (int i = 0; i < 17; i++)
      begin
         sel = i[3:0];
         ctrl.power = (i < 16);
         repeat (4) @(negedge clk_in);
         cnt = 0;
         repeat (3072) @(negedge clk_in) cnt += (base_t === 1'b1);
         `CHK(cnt, i < 11 ? 3072 >> i : (i == 11 ? 512 : 0))
      end
      $display("base clock rates done");
      for (int j = 0; j < 3; j++)
      begin
         ctrl = '1;
         sel = 4'h0;
         k = 8'h04 + 8'($unsigned($random(seed)) % 12);
         more = 1'b1;
         wr = 1'b1;
         wait_end(0);
         `CHK(t, 22 * k + 1)
         more = 1'b0;
         wr = 1'b1;
         cnt = 0;
         wait_end(0);
         `CHK(t, 22 * k + 2)
         `CHK(cnt, 11)
         ctrl.tx_enable = 1'b0;
         start = 1'b1;
         @(negedge clk_in);
         start = 1'b0;
         // A restart at 4k lands between the earlier frame's sampling instants.
         repeat (4 * k - 1) @(negedge clk_in);
         start = 1'b1;
         cnt = 0;
         wait_end(1);
         `CHK(cnt, 11)
         `CHK(ts, 21 * k + 1)
         `CHK(t, 22 * k + 1)
         cnt = 0;
         repeat (100) @(negedge clk_in) cnt += (rx_s === 1'b1);
         `CHK(cnt, 0)
      end
      $display("frame timing done");
      ctrl.tx_enable = 1'b1;
      k = 8'h03;
      wr = 1'b1;
      cnt = 0;
      @(negedge clk_in);
      wr = 1'b0;
      cnt += (bit_t === 1'b1);
      repeat (59) @(negedge clk_in) cnt += (bit_t === 1'b1);
      `CHK(div_err, 1'b1)
      `CHK(cnt, 0)
      k = 8'h04;
      repeat (3) @(negedge clk_in);
      `CHK(div_err, 1'b0)
      $display("divisor range done");
      test_done();
   end
   initial
   begin
      // The tests take about 55,000 cycles; 80,000 leaves room yet ends a hang early.
      #640000;
      err_count++;
      test_done();
   end
endmodule
